// *** tcpm_pkg.sv ***
package tcpm_pkg;
    // sources that may feed a first-stage lane in the digital crossbar
    localparam int unsigned NUM_XPIN = 6;
    localparam logic [2:0] XP_SER_RX = 3'h0;
    localparam logic [2:0] XP_SER_TX = 3'h1;
    localparam logic [2:0] XP_LS_FWD = 3'h2;
    localparam logic [2:0] XP_LS_RET = 3'h3;
    localparam logic [2:0] XP_GIO_A = 3'h4;
    localparam logic [2:0] XP_GIO_B = 3'h5;
    localparam int unsigned NUM_LANE = 3;
    // per-pin crossbar route: lane select and tx/rx leg
    localparam logic [2:0] XSEL_RST = 3'h0;
    localparam logic [1:0] LANE_NONE = 2'h3;
    // mux source codes for top/bottom pairs
    localparam logic [2:0] SRC_OFF = 3'h0;
    localparam logic [2:0] SRC_ROOT = 3'h1;
    localparam logic [2:0] SRC_ENDP = 3'h2;
    localparam logic [2:0] SRC_PRB1 = 3'h3;
    localparam logic [2:0] SRC_PRB3 = 3'h4;
    localparam logic [2:0] SRC_AUX = 3'h5;
    localparam logic [2:0] SRC_LANE = 3'h6;
    localparam logic [2:0] SRC_PROBE = 3'h7;
    // sideband sources
    localparam logic [1:0] SB_OFF = 2'h0;
    localparam logic [1:0] SB_LANE = 2'h1;
    localparam logic [1:0] SB_LSX = 2'h2;
    localparam logic [1:0] SB_ANALOG = 2'h3;
    localparam int unsigned NUM_PORT = 6;
    localparam logic [5:0] PORT_ZERO = 6'h00;
    typedef enum logic [2:0] {
        TCPM_ORIENT_UNKNOWN = 3'b001,
        TCPM_ORIENT_NORMAL = 3'b010,
        TCPM_ORIENT_REVERSE = 3'b100
    } tcpm_orient_t;
endpackage

// *** tcpm_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcpm_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule
`default_nettype wire

// *** tcpm_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - cable power reaches one config-channel pin only, chosen by orientation, never both.
// - the unpowered config-channel pin is joined to the protocol modem path.
// - current-limit level selectable between two; limit engages above selected level.
// - top and bottom D+/D- pairs swap roles with cable orientation.
// - sideband pair swaps when reversed, passes straight when normal.
// - positive legs go to D+ or sideband one; negatives to D- or two.
// - top/bottom connections swap with orientation, and the sideband crossbar flips too.
// - lane0 top, lane1 bottom, lane2 sideband; tx first pin, rx second.
// - firmware maps serial pins and general pins onto any core lane.
// - each crossbar pin is individually an input or output.
// - after reset serial transmit pin copies serial receive pin.
// - serial and low-speed sideband paths have separate tri-state enables.
// - low-speed sideband pair can act as analog pass switches.
// - core-facing paths are sampled and driven only on clock edges.
// - enabled edge comparators raise an interrupt on input switching.
// - each port output has its own pull-up and pull-down selection.
// - clamp follows its pin's second-stage path: in step for sideband pins, one cycle late for top/bottom pins.
module tcpm_top
    import tcpm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic orient_valid_i,
    input wire logic orient_reverse_i,
    input wire logic cable_power_en_i,
    input wire logic cable_power_current_limit_sel_i,
    input wire logic cable_power_overcurrent_i,
    output logic cc_a_power_o,
    output logic cc_b_power_o,
    output logic cc_a_modem_o,
    output logic cc_b_modem_o,
    output logic limit_level_o,
    output logic limit_active_o,
    input wire logic [2:0] pair_src_i,
    input wire logic [1:0] sb_src_i,
    output logic [2:0] top_src_o,
    output logic [2:0] bottom_src_o,
    output logic [1:0] sb_mode_o,
    output logic sb_swap_o,
    input wire logic [NUM_XPIN-1:0] xpin_in_i,
    input wire logic [NUM_XPIN-1:0] xpin_dir_out_i,
    input wire logic [NUM_XPIN-1:0] xpin_oe_en_i,
    input wire logic [2*NUM_XPIN-1:0] xpin_lane_i,
    input wire logic xbar_cfg_valid_i,
    output logic [NUM_XPIN-1:0] xpin_out_o,
    output logic [NUM_XPIN-1:0] xpin_oe_o,
    input wire logic [NUM_LANE-1:0] lane_tx_i,
    output logic [NUM_LANE-1:0] lane_rx_o,
    output logic [NUM_LANE-1:0] lane_to_pin_o,
    input wire logic [NUM_LANE-1:0] lane_from_pin_i,
    input wire logic [NUM_PORT-1:0] port_in_i,
    input wire logic [NUM_PORT-1:0] cmp_en_i,
    output logic [NUM_PORT-1:0] edge_irq_o,
    input wire logic [NUM_PORT-1:0] pull_up_sel_i,
    input wire logic [NUM_PORT-1:0] pull_dn_sel_i,
    output logic [NUM_PORT-1:0] pull_up_o,
    output logic [NUM_PORT-1:0] pull_dn_o,
    output logic [NUM_PORT-1:0] clamp_en_o
);
    import tcpm_pkg::*;

    tcpm_orient_t orient_r;
    logic [NUM_XPIN-1:0] xin_s;
    logic [NUM_LANE-1:0] lin_s;
    logic [NUM_PORT-1:0] pin_s;
    logic [NUM_PORT-1:0] pin_d_r;
    logic [2:0] async_s;
    logic known;
    logic rev;
    logic [NUM_PORT-1:0] closed;

    // pin-domain inputs pass two flops before any logic reads them
    tcpm_sync #(.W(NUM_XPIN)) u_sx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(xpin_in_i),
        .q_o(xin_s)
    );
    tcpm_sync #(.W(NUM_LANE)) u_sl (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(lane_from_pin_i),
        .q_o(lin_s)
    );
    tcpm_sync #(.W(NUM_PORT)) u_sp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(port_in_i),
        .q_o(pin_s)
    );
    // reverse travels with valid so the latched side never comes from a half-synced pair
    tcpm_sync #(.W(3)) u_so (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({orient_reverse_i, cable_power_overcurrent_i, orient_valid_i}),
        .q_o(async_s)
    );

    // one-hot registered orientation state: unknown, normal or reverse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            orient_r <= TCPM_ORIENT_UNKNOWN;
        end else if (!async_s[0]) begin
            orient_r <= TCPM_ORIENT_UNKNOWN;
        end else if (orient_r == TCPM_ORIENT_UNKNOWN) begin
            orient_r <= async_s[2] ? TCPM_ORIENT_REVERSE : TCPM_ORIENT_NORMAL;
        end
    end

    assign known = (orient_r != TCPM_ORIENT_UNKNOWN);
    assign rev = (orient_r == TCPM_ORIENT_REVERSE);

    // config-channel power and modem steering
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cc_a_power_o <= 1'b0;
            cc_b_power_o <= 1'b0;
            cc_a_modem_o <= 1'b0;
            cc_b_modem_o <= 1'b0;
        end else begin
            cc_a_power_o <= known && cable_power_en_i && !rev;
            cc_b_power_o <= known && cable_power_en_i && rev;
            cc_a_modem_o <= known && rev;
            cc_b_modem_o <= known && !rev;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            limit_level_o <= 1'b0;
            limit_active_o <= 1'b0;
        end else begin
            limit_level_o <= cable_power_current_limit_sel_i;
            limit_active_o <= async_s[1] && (cc_a_power_o || cc_b_power_o);
        end
    end

    function automatic logic [2:0] pair_legal(input logic [2:0] s);
        // lane codes are not legal from the pair select; lanes hard-wire per pair
        pair_legal = (s == SRC_LANE) ? SRC_OFF : s;
    endfunction

    // orientation swaps the selections: top takes the lane when reversed, bottom when normal; the other takes the pair select
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            top_src_o <= SRC_OFF;
            bottom_src_o <= SRC_OFF;
            sb_mode_o <= SB_OFF;
            sb_swap_o <= 1'b0;
        end else begin
            top_src_o <= known ? (rev ? SRC_LANE : pair_legal(pair_src_i)) : SRC_OFF;
            bottom_src_o <= known ? (rev ? pair_legal(pair_src_i) : SRC_LANE) : SRC_OFF;
            sb_mode_o <= known ? sb_src_i : SB_OFF;
            sb_swap_o <= known && rev;
        end
    end
    // root port and endpoint exist only in pair_legal codes, never on sideband

    // digital crossbar
    logic [NUM_LANE-1:0] lane_rx_nxt;
    always_comb begin
        lane_rx_nxt = '0;
        for (int p = 0; p < NUM_XPIN; p++) begin
            if (!xpin_dir_out_i[p] && xpin_lane_i[2*p +: 2] != LANE_NONE) begin
                lane_rx_nxt[xpin_lane_i[2*p +: 2]] = xin_s[p];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lane_rx_o <= '0;
            lane_to_pin_o <= '0;
        end else begin
            lane_rx_o <= lane_rx_nxt;
            lane_to_pin_o <= known ? lane_tx_i : '0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_XPIN; g++) begin : g_xp
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    xpin_out_o[g] <= 1'b0;
                    xpin_oe_o[g] <= (g == XP_SER_TX);
                end else if (!xbar_cfg_valid_i) begin
                    xpin_out_o[g] <= (g == XP_SER_TX) ? xin_s[XP_SER_RX] : 1'b0;
                    xpin_oe_o[g] <= (g == XP_SER_TX);
                end else begin
                    xpin_out_o[g] <= (xpin_lane_i[2*g +: 2] == LANE_NONE) ? 1'b0
                        : lin_s[xpin_lane_i[2*g +: 2]];
                    xpin_oe_o[g] <= xpin_dir_out_i[g] && xpin_oe_en_i[g];
                end
            end
        end
    endgenerate

    // edge monitors, pulls and clamps
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_d_r <= PORT_ZERO;
            edge_irq_o <= PORT_ZERO;
        end else begin
            pin_d_r <= pin_s;
            edge_irq_o <= cmp_en_i & (pin_s ^ pin_d_r);
        end
    end

    assign closed = known ? {sb_src_i != SB_OFF, sb_src_i != SB_OFF,
        {2{bottom_src_o != SRC_OFF}}, {2{top_src_o != SRC_OFF}}} : PORT_ZERO;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pull_up_o <= PORT_ZERO;
            pull_dn_o <= PORT_ZERO;
            clamp_en_o <= PORT_ZERO;
        end else begin
            pull_up_o <= pull_up_sel_i;
            pull_dn_o <= pull_dn_sel_i;
            clamp_en_o <= closed;
        end
    end

    a_cc_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
        !(cc_a_power_o && cc_b_power_o)) else $error("both cc pins powered");
    a_cc_modem_other: assert property (@(posedge clk_i) disable iff (rst_i)
        cc_a_power_o |-> cc_b_modem_o && !cc_a_modem_o) else $error("modem not on other pin");
    a_limit_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        limit_level_o == $past(cable_power_current_limit_sel_i)) else $error("limit level stale");
    a_sb_swap: assert property (@(posedge clk_i) disable iff (rst_i)
        sb_swap_o |-> orient_r == TCPM_ORIENT_REVERSE) else $error("swap in normal orientation");
    a_no_early_path: assert property (@(posedge clk_i) disable iff (rst_i)
        orient_r == TCPM_ORIENT_UNKNOWN |=> !cc_a_power_o && !cc_b_power_o)
        else $error("power before orientation");
    a_edge_irq: assert property (@(posedge clk_i) disable iff (rst_i)
        |edge_irq_o |-> |$past(cmp_en_i)) else $error("irq from disabled comparator");
    a_bypass_default: assert property (@(posedge clk_i) disable iff (rst_i)
        !xbar_cfg_valid_i ##1 !xbar_cfg_valid_i |-> xpin_oe_o[XP_SER_TX]
        && xpin_out_o[XP_SER_TX] == $past(xin_s[XP_SER_RX])) else $error("bypass broken");
    a_clamp_closed: assert property (@(posedge clk_i) disable iff (rst_i)
        clamp_en_o == $past(closed)) else $error("clamp not tracking path");
    a_modem_b_side: assert property (@(posedge clk_i) disable iff (rst_i)
        cc_b_power_o |-> cc_a_modem_o && !cc_b_modem_o) else $error("modem not on pin a");
    a_limit_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        limit_active_o |-> $past(cc_a_power_o || cc_b_power_o)) else $error("limit while unpowered");
    a_pair_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !known |=> top_src_o == SRC_OFF && bottom_src_o == SRC_OFF) else $error("pair path early");
    a_pair_lane_one: assert property (@(posedge clk_i) disable iff (rst_i)
        known |=> (top_src_o == SRC_LANE) != (bottom_src_o == SRC_LANE))
        else $error("lane pair not unique");
    a_swap_normal: assert property (@(posedge clk_i) disable iff (rst_i)
        known && !rev |=> !sb_swap_o) else $error("swap while normal");
    a_sb_mode_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !known |=> sb_mode_o == SB_OFF) else $error("sideband mode early");
    a_lane_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !known |=> lane_to_pin_o == '0) else $error("lane driven early");
    a_oe_config: assert property (@(posedge clk_i) disable iff (rst_i)
        xbar_cfg_valid_i |=> xpin_oe_o == $past(xpin_dir_out_i & xpin_oe_en_i))
        else $error("output enable wrong");
    a_pull_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        pull_up_o == $past(pull_up_sel_i) && pull_dn_o == $past(pull_dn_sel_i))
        else $error("pull select stale");
    a_clamp_unknown: assert property (@(posedge clk_i) disable iff (rst_i)
        !known |=> clamp_en_o == PORT_ZERO) else $error("clamp before orientation");
endmodule
`default_nettype wire

// *** tcpm_partner_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// cable and far port: attach detection, plug flip and a shorted cable load
module tcpm_partner_model (
    input wire logic clk_i,
    input wire logic attach_i,
    input wire logic flip_i,
    input wire logic short_i,
    output logic orient_valid_o,
    output logic orient_reverse_o,
    output logic overcurrent_o
);
    // the plug side is fixed for the whole attach, so flip is shown with attach
    always_ff @(posedge clk_i) begin
        orient_valid_o <= attach_i;
        orient_reverse_o <= flip_i;
        overcurrent_o <= short_i & attach_i;
    end
endmodule
`default_nettype wire

// *** test_tcpm_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_tcpm_top;
    import tcpm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic attach = 1'b0;
    logic flip = 1'b0;
    logic short_c = 1'b0;
    logic ov, orv, oc, pw_en = 1'b0, lim_sel = 1'b0, xvalid = 1'b0;
    logic [2:0] pair_src = SRC_OFF, ltx = 3'h0, lfrom = 3'h0;
    logic [1:0] sb_src = SB_OFF;
    logic [5:0] xin = 6'h00, xdir = 6'h00, xoe = 6'h00;
    logic [5:0] pin = 6'h00, cmp = 6'h00, pus = 6'h00, pds = 6'h00;
    logic [11:0] xlane = 12'hfff;
    logic ca_p, cb_p, ca_m, cb_m, lvl, lact, sbs;
    logic [2:0] tsrc, bsrc, lrx, lpin;
    logic [1:0] sbm;
    logic [5:0] xout, xoeo, irq, puo, pdo, clo, seen;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    tcpm_partner_model i_tcpm_partner_model (.clk_i(clk_i), .attach_i(attach),
        .flip_i(flip), .short_i(short_c), .orient_valid_o(ov),
        .orient_reverse_o(orv), .overcurrent_o(oc));

    tcpm_top i_tcpm_top (.clk_i(clk_i), .rst_i(rst_i), .orient_valid_i(ov),
        .orient_reverse_i(orv), .cable_power_en_i(pw_en),
        .cable_power_current_limit_sel_i(lim_sel), .cable_power_overcurrent_i(oc),
        .cc_a_power_o(ca_p), .cc_b_power_o(cb_p), .cc_a_modem_o(ca_m),
        .cc_b_modem_o(cb_m), .limit_level_o(lvl), .limit_active_o(lact),
        .pair_src_i(pair_src), .sb_src_i(sb_src), .top_src_o(tsrc),
        .bottom_src_o(bsrc), .sb_mode_o(sbm), .sb_swap_o(sbs), .xpin_in_i(xin),
        .xpin_dir_out_i(xdir), .xpin_oe_en_i(xoe), .xpin_lane_i(xlane),
        .xbar_cfg_valid_i(xvalid), .xpin_out_o(xout), .xpin_oe_o(xoeo),
        .lane_tx_i(ltx), .lane_rx_o(lrx), .lane_to_pin_o(lpin),
        .lane_from_pin_i(lfrom), .port_in_i(pin), .cmp_en_i(cmp),
        .edge_irq_o(irq), .pull_up_sel_i(pus), .pull_dn_sel_i(pds),
        .pull_up_o(puo), .pull_dn_o(pdo), .clamp_en_o(clo));

    initial forever #25 clk_i = ~clk_i;

    task automatic summarize();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // the whole sequence needs well under 300 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // waits n edges, then steps off the edge so outputs have settled
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wt(2);
        chk("xpin_oe_o", 8'h02, {2'b00, xoeo});
        chk("cc paths", 8'h00, {4'h0, ca_p, cb_p, ca_m, cb_m});
        @(posedge clk_i);
        xin <= 6'h01;
        pw_en <= 1'b1;
        pair_src <= SRC_ROOT;
        sb_src <= SB_LANE;
        wt(6);
        chk("bypass", 8'h01, {7'h00, xout[1]});
        chk("cc idle", 8'h00, {4'h0, ca_p, cb_p, ca_m, cb_m});
        chk("clamp idle", 8'h00, {2'b00, clo});
        // first attach upright, then a reattach flipped
        for (int f = 0; f < 2; f++) begin
            @(posedge clk_i);
            attach <= 1'b1;
            flip <= f[0];
            wt(8);
            chk("cc paths", f ? 8'h06 : 8'h09, {4'h0, ca_p, cb_p, ca_m, cb_m});
            chk("sb_swap_o", {7'h00, f[0]}, {7'h00, sbs});
            chk("top_src_o", {5'h00, f ? SRC_LANE : SRC_ROOT}, {5'h00, tsrc});
            chk("bottom_src_o", {5'h00, f ? SRC_ROOT : SRC_LANE}, {5'h00, bsrc});
            @(posedge clk_i);
            attach <= f[0];
            wt(8);
        end
        chk("cc kept", 8'h06, {4'h0, ca_p, cb_p, ca_m, cb_m});
        chk("clamp live", 8'h3f, {2'b00, clo});
        chk("sb_mode_o", {6'h00, SB_LANE}, {6'h00, sbm});
        @(posedge clk_i);
        xvalid <= 1'b1;
        xlane <= 12'hff4;
        xdir <= 6'h02;
        xoe <= 6'h00;
        lfrom <= 3'h2;
        ltx <= 3'h5;
        wt(6);
        chk("lane_rx_o", 8'h01, {5'h00, lrx});
        chk("lane_to_pin_o", 8'h05, {5'h00, lpin});
        chk("xpin_out_o", 8'h02, {2'b00, xout});
        chk("xpin_oe_o", 8'h00, {2'b00, xoeo});
        @(posedge clk_i);
        xoe <= 6'h02;
        wt(3);
        chk("xpin_oe_o", 8'h02, {2'b00, xoeo});
        for (int s = 1; s >= 0; s--) begin
            @(posedge clk_i);
            lim_sel <= s[0];
            short_c <= s[0];
            wt(6);
            chk("limit_level_o", {7'h00, s[0]}, {7'h00, lvl});
            chk("limit_active_o", {7'h00, s[0]}, {7'h00, lact});
        end
        @(posedge clk_i);
        pus <= 6'h2a;
        pds <= 6'h15;
        cmp <= 6'h01;
        wt(3);
        chk("pull_up_o", 8'h2a, {2'b00, puo});
        chk("pull_dn_o", 8'h15, {2'b00, pdo});
        // firmware keeps comparator 1 off, as for a pin at an analog level
        @(posedge clk_i);
        pin <= 6'h03;
        seen = 6'h00;
        checked++;
        repeat (8) begin
            wt(1);
            if (irq[0] === 1'b1 && seen[0] === 1'b1) begin
                mismatches++;
                $display("BAD edge_irq_o expected one pulse seen more");
            end
            seen = seen | irq;
        end
        chk("edge_irq_o", 8'h01, {2'b00, seen});
        summarize();
    end
endmodule
`default_nettype wire
